// ==== tcs_consts.svh ====
// Timing and setting constants for the trip circuit monitor
`ifndef TCS_CONSTS_SVH
`define TCS_CONSTS_SVH
`define TCS_CLK_HZ          10000000
`define TCS_DELAY_MIN_CS    16'h000A
`define TCS_DELAY_MAX_CS    16'h03E8
`define TCS_DELAY_DEF_CS    16'h0014
`define TCS_CS_NS           10000000
`define TCS_CLK_NS          100
`define TCS_TICK_CYCLES     (`TCS_CS_NS / `TCS_CLK_NS)
`define TCS_TICK_W          17
`define TCS_CS_W            16
`endif

// ==== tcs_pkg.sv ====
// Types for the trip circuit monitor
`default_nettype none
package tcs_pkg;
  typedef enum logic [0:0] {
    TCS_MODE_CLOSED = 1'b0,
    TCS_MODE_EITHER = 1'b1
  } tcs_mode_type;
  typedef struct packed {
    logic         function_active;
    logic         block_allow_setting;
    tcs_mode_type mode;
    logic [15:0]  supervision_alarm_delay;
  } tcs_cfg_type;
  typedef struct packed {
    logic active;
    logic blocked_flag;
    logic alarm;
    logic not_possible;
  } tcs_status_type;
  typedef enum logic [2:0] {
    TCS_ST_IDLE    = 3'b001,
    TCS_ST_TIMING  = 3'b010,
    TCS_ST_ALARM   = 3'b100
  } tcs_state_type;
endpackage
`default_nettype wire

// ==== tcs_sync.sv ====
// Two-flop synchroniser for a bank of pin inputs
`default_nettype none
module tcs_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          meta_q[g]   <= 1'b0;
          sync_out[g] <= 1'b0;
        end else begin
          meta_q[g]   <= async_in[g];
          sync_out[g] <= meta_q[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== tcs_monitor.sv ====
// Trip circuit monitor: breaker contact supervision with delayed alarm
// What this block does
// - Function setting off means no supervision, alarm
// - Block allow ignored without assigned blocking input
// - Alarm delay 0.10 to 10.00 s, default 0.2
// - Lost control voltage alarms after full delay
// - Broken control wire alarms after full delay
// - No position source assigned raises not-possible flag while function setting on
// - Inputs: 52a, 52b, two blocks, position source
// - Outputs: active, blocked, supervision alarm, not possible
// - Mode Closed supervises closed; Either both positions
// - Input one when closed, two when open
`include "tcs_consts.svh"
`default_nettype none
module tcs_monitor #(
  // Clocks per 10 ms delay step
  parameter int TICK_CYCLES = `TCS_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                sys_rst_in,
  // Settings
  input  wire tcs_pkg::tcs_cfg_type cfg_in,
  input  wire logic                block_one_assigned_in,
  input  wire logic                block_two_assigned_in,
  input  wire logic                position_assigned_in,
  // Breaker contacts and blocking pins
  input  wire logic                aux_closed_52a_in,
  input  wire logic                aux_open_52b_in,
  input  wire logic                external_block_one_in,
  input  wire logic                external_block_two_in,
  input  wire logic                breaker_position_source_in,
  // Status
  output tcs_pkg::tcs_status_type  status_out
);
  logic [3:0]                 pins_s;
  logic                       a52_s;
  logic                       b52_s;
  logic                       blk1_s;
  logic                       blk2_s;
  logic                       pos_closed_s;
  logic                       blocked_d;
  logic                       supervise_d;
  logic                       fault_d;
  logic [15:0]                delay_cs;
  logic [`TCS_TICK_W-1:0]     tick_cnt_q;
  logic [`TCS_CS_W-1:0]       cs_cnt_q;
  logic                       fault_q;
  logic                       tick;
  tcs_pkg::tcs_state_type     state_q;
  tcs_pkg::tcs_status_type    status_q;

  tcs_sync #(.WIDTH(4)) u_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({aux_closed_52a_in, aux_open_52b_in,
                  external_block_one_in, external_block_two_in}),
    .sync_out   (pins_s)
  );

  logic [1:0] pos_meta_q;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pos_meta_q <= 2'h0;
    end else begin
      pos_meta_q <= {pos_meta_q[0], breaker_position_source_in};
    end
  end

  assign a52_s        = pins_s[3];
  assign b52_s        = pins_s[2];
  assign blk1_s       = pins_s[1];
  assign blk2_s       = pins_s[0];
  assign pos_closed_s = pos_meta_q[1];

  always_comb begin
    if (cfg_in.supervision_alarm_delay < `TCS_DELAY_MIN_CS) begin
      delay_cs = `TCS_DELAY_MIN_CS;
    end else if (cfg_in.supervision_alarm_delay > `TCS_DELAY_MAX_CS) begin
      delay_cs = `TCS_DELAY_MAX_CS;
    end else begin
      delay_cs = cfg_in.supervision_alarm_delay;
    end
  end

  always_comb begin
    // assigned true block holds off supervision
    blocked_d = cfg_in.function_active && cfg_in.block_allow_setting &&
                ((block_one_assigned_in && blk1_s) ||
                 (block_two_assigned_in && blk2_s));
    supervise_d = cfg_in.function_active && !blocked_d && position_assigned_in;
    // input one closed, input two open
    // lost voltage drops the monitored input
    // broken wire drops the monitored input
    if (pos_closed_s) begin
      fault_d = !a52_s;
    end else begin
      // open position only in Either mode
      fault_d = (cfg_in.mode == tcs_pkg::TCS_MODE_EITHER) && !b52_s;
    end
    fault_d = fault_d && supervise_d;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
    end
  end

  // Centisecond tick prescaler, restarted with each fault onset
  assign tick = (tick_cnt_q == `TCS_TICK_W'(TICK_CYCLES - 1));
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tick_cnt_q <= '0;
    end else if (!fault_q || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + `TCS_TICK_W'(1);
    end
  end

  // timer runs only while fault persists
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q  <= tcs_pkg::TCS_ST_IDLE;
      cs_cnt_q <= '0;
    end else begin
      unique case (state_q)
        tcs_pkg::TCS_ST_IDLE: begin
          cs_cnt_q <= '0;
          if (fault_q) begin
            state_q <= tcs_pkg::TCS_ST_TIMING;
          end
        end
        tcs_pkg::TCS_ST_TIMING: begin
          if (!fault_q) begin
            state_q  <= tcs_pkg::TCS_ST_IDLE;
            cs_cnt_q <= '0;
          end else if (tick) begin
            cs_cnt_q <= cs_cnt_q + `TCS_CS_W'(1);
            if (cs_cnt_q + `TCS_CS_W'(1) >= delay_cs) begin
              state_q <= tcs_pkg::TCS_ST_ALARM;
            end
          end
        end
        tcs_pkg::TCS_ST_ALARM: begin
          if (!fault_q) begin
            state_q  <= tcs_pkg::TCS_ST_IDLE;
            cs_cnt_q <= '0;
          end
        end
        default: begin
          state_q  <= tcs_pkg::TCS_ST_IDLE;
          cs_cnt_q <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      status_q <= '0;
    end else begin
      status_q.active       <= cfg_in.function_active;
      status_q.blocked_flag <= blocked_d;
      status_q.alarm        <= (state_q == tcs_pkg::TCS_ST_ALARM) && fault_q;
      status_q.not_possible <= cfg_in.function_active && !position_assigned_in;
    end
  end
  assign status_out = status_q;

  a_inactive_no_alarm: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !cfg_in.function_active [*2] |=> !status_out.alarm)
    else $error("alarm while function inactive");
  a_unassigned_no_block: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!block_one_assigned_in && !block_two_assigned_in) |=> !status_out.blocked_flag)
    else $error("blocked without assigned input");
  a_blocked_no_alarm: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    blocked_d |-> ##2 !status_out.alarm)
    else $error("alarm while blocked");
  // alarm only with a standing fault
  a_alarm_needs_fault: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    status_out.alarm |-> $past(fault_q))
    else $error("alarm without fault");
  // alarm needs fault held for the minimum delay
  a_alarm_after_delay: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $rose(status_out.alarm) |-> $past(fault_q, 2) && (cs_cnt_q >= `TCS_DELAY_MIN_CS))
    else $error("alarm before delay");
  // counter never passes the maximum delay setting
  a_counter_bound: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cs_cnt_q <= `TCS_DELAY_MAX_CS)
    else $error("delay counter out of range");
  a_not_possible: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cfg_in.function_active && !position_assigned_in |=> status_out.not_possible)
    else $error("not-possible flag missing");
  a_closed_mode_open: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cfg_in.mode == tcs_pkg::TCS_MODE_CLOSED && !pos_closed_s |=> !fault_q)
    else $error("fault in closed mode while open");
  a_active_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cfg_in.function_active |=> status_out.active)
    else $error("active flag missing");
  c_alarm: cover property (@(posedge clk_in) $rose(status_out.alarm));
  c_blocked: cover property (@(posedge clk_in) $rose(status_out.blocked_flag));
  c_restart: cover property (@(posedge clk_in) state_q == tcs_pkg::TCS_ST_TIMING && !fault_q);
  c_open_alarm: cover property (@(posedge clk_in) !pos_closed_s && status_out.alarm);
endmodule
`default_nettype wire

// ==== tcs_breaker_model.sv ====
// Breaker auxiliary contact model driving the trip circuit monitor pins
`default_nettype none
module tcs_breaker_model (
  // Commands from the bench
  input  wire logic closed_in,
  input  wire logic volt_lost_in,
  input  wire logic wire_broken_in,
  // Contacts seen by the monitor
  output logic      aux_closed_52a_out,
  output logic      aux_open_52b_out,
  output logic      position_out
);
  timeunit 1ns;
  timeprecision 1ns;
  assign aux_closed_52a_out = !volt_lost_in && !(wire_broken_in && closed_in);
  assign aux_open_52b_out   = !volt_lost_in && !(wire_broken_in && !closed_in);
  assign position_out       = closed_in;
endmodule
`default_nettype wire

// ==== tb_trip_circuit_supervision.sv ====
// Self-checking bench for the trip circuit monitor
`include "tcs_consts.svh"
`default_nettype none
module tb_trip_circuit_supervision;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    clk_in = 1'b0;
  logic                    sys_rst_in = 1'b1;
  tcs_pkg::tcs_cfg_type    cfg = '0;
  logic [2:0]              asg = 3'b111;
  logic [1:0]              blk = 2'b00;
  logic                    closed = 1'b1;
  logic                    lost = 1'b0;
  logic                    broken = 1'b0;
  logic                    a52;
  logic                    b52;
  logic                    pos;
  tcs_pkg::tcs_status_type st;
  logic [7:0]              lf = 8'h4E;
  int                      errors = 0;
  int                      n_tests = 0;
  localparam int           TICK = 20;
  always #50 clk_in = ~clk_in;
  tcs_breaker_model i_tcs_breaker_model (.closed_in(closed), .volt_lost_in(lost),
    .wire_broken_in(broken), .aux_closed_52a_out(a52), .aux_open_52b_out(b52),
    .position_out(pos));
  tcs_monitor #(.TICK_CYCLES(TICK)) i_tcs_monitor (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .cfg_in(cfg),
    .block_one_assigned_in(asg[2]), .block_two_assigned_in(asg[1]),
    .position_assigned_in(asg[0]), .aux_closed_52a_in(a52), .aux_open_52b_in(b52),
    .external_block_one_in(blk[1]), .external_block_two_in(blk[0]),
    .breaker_position_source_in(pos), .status_out(st));
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic flt_exp(input logic c, input logic m, input logic l, input logic b);
    return (l | b) & (c | m);
  endfunction
  function automatic int clamp_cs(input logic [15:0] d);
    if (d < `TCS_DELAY_MIN_CS) begin
      return int'(`TCS_DELAY_MIN_CS);
    end
    if (d > `TCS_DELAY_MAX_CS) begin
      return int'(`TCS_DELAY_MAX_CS);
    end
    return int'(d);
  endfunction
  function automatic tcs_pkg::tcs_status_type expect_st(input logic al);
    tcs_pkg::tcs_status_type e;
    e.active       = cfg.function_active;
    e.blocked_flag = cfg.function_active & cfg.block_allow_setting & (|(asg[2:1] & blk));
    e.alarm        = al;
    e.not_possible = cfg.function_active & ~asg[0];
    return e;
  endfunction
  task automatic chk(input tcs_pkg::tcs_status_type g, input tcs_pkg::tcs_status_type e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic results;
    $display("Checks %0d, errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic run_fault(input logic c, input logic m, input logic l, input logic b,
                           input logic [15:0] d, input logic fn, input int pre, input logic bk);
    logic al;
    int   w;
    al = fn & flt_exp(c, m, l, b);
    w = clamp_cs(d) * TICK + 3;
    @(posedge clk_in);
    #1;
    cfg = '{fn, 1'b0, tcs_pkg::tcs_mode_type'(m), d};
    asg = 3'b111;
    blk = 2'b00;
    closed = c;
    repeat (6) @(posedge clk_in);
    #1;
    if (pre > 0) begin
      lost = l;
      broken = b;
      repeat (pre) @(posedge clk_in);
      #1;
      lost = 1'b0;
      broken = 1'b0;
      repeat (4) @(posedge clk_in);
      #1;
      chk(st, expect_st(1'b0));
    end
    lost = l;
    broken = b;
    repeat (w) @(posedge clk_in);
    #1;
    chk(st, expect_st(1'b0));
    @(posedge clk_in);
    #1;
    chk(st, expect_st(al));
    if (bk) begin
      cfg.block_allow_setting = 1'b1;
      blk = 2'b10;
    end else begin
      lost = 1'b0;
      broken = 1'b0;
    end
    repeat (3) @(posedge clk_in);
    #1;
    chk(st, expect_st(al));
    @(posedge clk_in);
    #1;
    chk(st, expect_st(1'b0));
    lost = 1'b0;
    broken = 1'b0;
    blk = 2'b00;
  endtask
  initial begin
    repeat (40000) @(posedge clk_in);
    errors++;
    results();
  end
  initial begin
    repeat (5) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    chk(st, '0);
    for (int i = 0; i < 300; i++) begin
      lf = nxt(lf);
      cfg.block_allow_setting = lf[5];
      cfg.mode = tcs_pkg::tcs_mode_type'(lf[7]);
      cfg.supervision_alarm_delay = 16'h000A + {8'h00, lf};
      asg = lf[4:2];
      blk = lf[1:0];
      lf = nxt(lf);
      cfg.function_active = lf[0] | lf[1];
      closed = lf[2];
      repeat (5) @(posedge clk_in);
      #1;
      chk(st, expect_st(1'b0));
    end
    run_fault(1'b1, 1'b0, 1'b0, 1'b1, 16'h000A, 1'b1, 0, 1'b0);
    run_fault(1'b0, 1'b1, 1'b1, 1'b0, 16'h0003, 1'b1, 100, 1'b0);
    run_fault(1'b0, 1'b0, 1'b0, 1'b1, 16'h000A, 1'b1, 0, 1'b0);
    run_fault(1'b1, 1'b1, 1'b1, 1'b0, 16'hFFFF, 1'b1, 0, 1'b0);
    run_fault(1'b1, 1'b0, 1'b0, 1'b1, 16'h000A + {8'h00, lf}, 1'b1, 0, 1'b1);
    run_fault(1'b1, 1'b0, 1'b1, 1'b0, 16'h000A, 1'b0, 0, 1'b0);
    run_fault(1'b0, 1'b1, 1'b0, 1'b1, `TCS_DELAY_DEF_CS, 1'b1, 0, 1'b0);
    results();
  end
endmodule
`default_nettype wire
